// ---- bmsl_pkg.sv ----
// Package of constants and the state type for the boot mode select loader.
// Summary of operation
// - Reset loads a kernel of up to 256 instructions first; host boot ends it at the word flagged last.
// - Boot data moves as 32-bit words via DMA.
// - Strap pin is an input during reset.
// - Strap low after delay selects EPROM boot.
// - After sampling, strap pin drives EPROM select in EPROM boot only.
// - Strap high means idle, await host/link.
// - EPROM boot reads 8-bit wide external memory.
// - After last host word, device runs code.
// - Link boot takes data from peer's link.
// - Finished kernel load then executes kernel.
// - Kernel memory is later overwritten and reused.
`default_nettype none
package bmsl_pkg;
    // Kernel length in instructions.
    localparam int unsigned KERNEL_WORDS = 256;
    // Width of the word counter.
    localparam int unsigned CNT_W = 9;
    // Kernel length sized for the counter.
    localparam logic [8:0] KERNEL_LAST = 9'h100;
    // Instruction word width.
    localparam int unsigned WORD_W = 32;
    // Byte lanes that make up one instruction.
    localparam int unsigned BYTES_PER_WORD = 4;
    // Width of the external EPROM data bus.
    localparam int unsigned EPROM_W = 8;
    // EPROM byte address width.
    localparam int unsigned EPROM_AW = 10;
    // Strap sampling delay after reset release, in cycles.
    localparam logic [3:0] STRAP_DELAY = 4'h8;
    // Boot mode codes.
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_EPROM = 2'h1;
    localparam logic [1:0] MODE_HOST = 2'h2;
    localparam logic [1:0] MODE_LINK = 2'h3;
    // Sequencer states.
    typedef enum logic [2:0] {
        BMSL_SAMPLE,
        BMSL_IDLE,
        BMSL_LOAD,
        BMSL_KERNEL,
        BMSL_DONE
    } bmsl_state_t;
endpackage : bmsl_pkg
`default_nettype wire

// ---- bmsl_sync.sv ----
// Two-flip-flop synchroniser for a bundle of pin levels.
`timescale 1ns/1ps
`default_nettype none
module bmsl_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_sys_i,
    input  wire logic         arst_n_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    // First stage; only the second stage reads it.
    logic [W-1:0] meta_ff;
    // Both stages are frozen with the clock enable like all other state.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_ff <= '0;
            q_o     <= '0;
        end else if (ce_i) begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule : bmsl_sync
`default_nettype wire

// ---- bmsl_packer.sv ----
// Packs four EPROM bytes into one 32-bit instruction, low byte first.
`timescale 1ns/1ps
`default_nettype none
module bmsl_packer
    import bmsl_pkg::*;
(
    input  wire logic                        clk_sys_i,
    input  wire logic                        arst_n_i,
    input  wire logic                        ce_i,
    input  wire logic                        clear_i,
    input  wire logic                        byte_vld_i,
    input  wire logic [bmsl_pkg::EPROM_W-1:0] byte_i,
    output logic                             word_vld_o,
    output logic      [bmsl_pkg::WORD_W-1:0] word_o
);
    // Lane index of the next byte.
    logic [1:0] lane_ff;
    // Each byte lands in its own lane; the fourth completes the word.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lane_ff    <= 2'h0;
            word_o     <= '0;
            word_vld_o <= 1'b0;
        end else if (ce_i) begin
            word_vld_o <= 1'b0;
            if (clear_i) begin
                lane_ff <= 2'h0;
            end else if (byte_vld_i) begin
                word_o[lane_ff*EPROM_W +: EPROM_W] <= byte_i;
                lane_ff <= lane_ff + 2'h1;
                word_vld_o <= (lane_ff == 2'h3);
            end
        end
    end
endmodule : bmsl_packer
`default_nettype wire

// ---- bmsl_loader.sv ----
// Boot sequencer: strap sampling, kernel load by DMA, hand-off.
`timescale 1ns/1ps
`default_nettype none
module bmsl_loader
    import bmsl_pkg::*;
(
    input  wire logic                       clk_sys_i,
    input  wire logic                       arst_n_i,
    input  wire logic                       ce_i,
    // Strap pin: input during reset, EPROM select afterwards in EPROM boot only.
    input  wire logic                       boot_source_strap_i,
    output logic                            boot_source_strap_o,
    output logic                            boot_source_strap_oe_o,
    // External EPROM read port (byte wide, one-cycle read latency pin side).
    output logic [bmsl_pkg::EPROM_AW-1:0]   eprom_addr_o,
    output logic                            eprom_rd_o,
    input  wire logic [bmsl_pkg::EPROM_W-1:0] eprom_data_i,
    // Host writes to the host boot DMA port, one word per strobe.
    input  wire logic                       host_boot_dma_port_wr_i,
    input  wire logic [bmsl_pkg::WORD_W-1:0] host_boot_dma_port_data_i,
    input  wire logic                       host_last_i,
    // Link port receive words from the peer.
    input  wire logic                       link_vld_i,
    input  wire logic [bmsl_pkg::WORD_W-1:0] link_data_i,
    // DMA channel write into internal memory.
    output logic                            dma_wr_o,
    output logic [bmsl_pkg::CNT_W-2:0]      dma_addr_o,
    output logic [bmsl_pkg::WORD_W-1:0]     dma_data_o,
    // Core control.
    output logic                            core_run_o,
    output logic                            kernel_done_o,
    output logic                            kernel_area_free_o,
    input  wire logic                       kernel_init_done_i,
    output logic [1:0]                      boot_mode_o
);
    // Synchronised pin inputs: strap, host strobes, link valid.
    logic [2:0] pin_sync;
    bmsl_sync #(.W(3)) u_sync (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .ce_i      (ce_i),
        .d_i       ({boot_source_strap_i, host_boot_dma_port_wr_i,
                     link_vld_i}),
        .q_o       (pin_sync)
    );
    logic strap_s;
    logic host_wr_s;
    logic link_vld_s;
    assign strap_s    = pin_sync[2];
    assign host_wr_s  = pin_sync[1];
    assign link_vld_s = pin_sync[0];

    // Host and link data buses are delayed two cycles to stay aligned with the strobes; the EPROM data bus one cycle.
    logic [WORD_W-1:0] host_d1_ff, host_d2_ff, link_d1_ff, link_d2_ff;
    logic              host_last_d1_ff, host_last_d2_ff;
    logic [EPROM_W-1:0] eprom_d1_ff;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            host_d1_ff      <= '0;
            host_d2_ff      <= '0;
            link_d1_ff      <= '0;
            link_d2_ff      <= '0;
            host_last_d1_ff <= 1'b0;
            host_last_d2_ff <= 1'b0;
            eprom_d1_ff     <= '0;
        end else if (ce_i) begin
            host_d1_ff      <= host_boot_dma_port_data_i;
            host_d2_ff      <= host_d1_ff;
            link_d1_ff      <= link_data_i;
            link_d2_ff      <= link_d1_ff;
            host_last_d1_ff <= host_last_i;
            host_last_d2_ff <= host_last_d1_ff;
            eprom_d1_ff     <= eprom_data_i;
        end
    end

    // Sequencer state and its bookkeeping.
    bmsl_state_t state_ff;
    logic [3:0]  delay_ff;     // Cycles since reset release.
    logic [1:0]  mode_ff;      // Latched boot mode.
    logic [CNT_W-1:0] cnt_ff;  // Kernel words written.
    logic        rd_pend_ff;   // EPROM byte requested last cycle.
    logic [1:0]  rd_gap_ff;    // Pin read pipeline.
    logic [EPROM_AW-1:0] raddr_ff;

    // Packed EPROM word.
    logic              pk_vld;
    logic [WORD_W-1:0] pk_word;
    bmsl_packer u_packer (
        .clk_sys_i  (clk_sys_i),
        .arst_n_i   (arst_n_i),
        .ce_i       (ce_i),
        .clear_i    (state_ff != BMSL_LOAD),
        .byte_vld_i (rd_gap_ff[1]),
        .byte_i     (eprom_d1_ff),
        .word_vld_o (pk_vld),
        .word_o     (pk_word)
    );

    // A word from whichever source the latched mode picked.
    logic              src_vld;
    logic [WORD_W-1:0] src_word;
    // A link word seen while idle is taken at once; the latched mode only
    // turns to link at that same edge, so the word would otherwise be lost.
    logic [1:0]        src_mode;
    assign src_mode = (state_ff == BMSL_IDLE && link_vld_s && !host_wr_s) ?
                      MODE_LINK : mode_ff;
    always_comb begin
        src_vld  = 1'b0;
        src_word = '0;
        case (src_mode)
            MODE_EPROM: begin
                src_vld  = pk_vld;
                src_word = pk_word;
            end
            MODE_HOST: begin
                src_vld  = host_wr_s;
                src_word = host_d2_ff;
            end
            MODE_LINK: begin
                src_vld  = link_vld_s;
                src_word = link_d2_ff;
            end
            default: begin
                src_vld  = 1'b0;
                src_word = '0;
            end
        endcase
    end

    // The strap is caught once, after a fixed delay, and held.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            delay_ff <= 4'h0;
            mode_ff  <= MODE_NONE;
        end else if (ce_i) begin
            if (state_ff == BMSL_SAMPLE) begin
                delay_ff <= delay_ff + 4'h1;
                if (delay_ff == STRAP_DELAY) begin
                    mode_ff <= strap_s ? MODE_HOST : MODE_EPROM;
                end
            end else if (state_ff == BMSL_IDLE && mode_ff == MODE_HOST &&
                         link_vld_s && !host_wr_s) begin
                mode_ff <= MODE_LINK;
            end
        end
    end

    // Main sequence: sample, wait or load, run kernel.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= BMSL_SAMPLE;
            cnt_ff   <= '0;
        end else if (ce_i) begin
            case (state_ff)
                BMSL_SAMPLE: begin
                    if (delay_ff == STRAP_DELAY) begin
                        state_ff <= strap_s ? BMSL_IDLE : BMSL_LOAD;
                    end
                end
                BMSL_IDLE, BMSL_LOAD: begin
                    // The first host or link word starts and feeds the load.
                    if (src_vld) begin
                        state_ff <= BMSL_LOAD;
                        cnt_ff <= cnt_ff + 9'h001;
                        if (cnt_ff == KERNEL_LAST - 9'h001 ||
                            (mode_ff == MODE_HOST && host_last_d2_ff)) begin
                            state_ff <= BMSL_KERNEL;
                        end
                    end
                end
                BMSL_KERNEL: begin
                    if (kernel_init_done_i) begin
                        state_ff <= BMSL_DONE;
                    end
                end
                BMSL_DONE: begin
                    state_ff <= BMSL_DONE;
                end
                default: begin
                    state_ff <= BMSL_SAMPLE;
                end
            endcase
        end
    end

    // EPROM fetch: one byte request at a time through the external port.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            raddr_ff   <= '0;
            rd_pend_ff <= 1'b0;
            rd_gap_ff  <= 2'h0;
        end else if (ce_i) begin
            rd_gap_ff <= {rd_gap_ff[0], rd_pend_ff};
            rd_pend_ff <= 1'b0;
            if (state_ff == BMSL_LOAD && mode_ff == MODE_EPROM &&
                !rd_pend_ff && rd_gap_ff == 2'h0) begin
                // The address wraps with the last byte's request; one more read, of byte 0, is requested at the same edge that ends the load.
                rd_pend_ff <= 1'b1;
                raddr_ff   <= raddr_ff + 10'h001;
            end
        end
    end

    // Registered outputs for pins, DMA and core control.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            boot_source_strap_o    <= 1'b1;
            boot_source_strap_oe_o <= 1'b0;
            eprom_addr_o           <= '0;
            eprom_rd_o             <= 1'b0;
            dma_wr_o               <= 1'b0;
            dma_addr_o             <= '0;
            dma_data_o             <= '0;
            core_run_o             <= 1'b0;
            kernel_done_o          <= 1'b0;
            kernel_area_free_o     <= 1'b0;
            boot_mode_o            <= MODE_NONE;
        end else if (ce_i) begin
            // Select is active low, driven only in EPROM mode after sampling.
            boot_source_strap_oe_o <= (mode_ff == MODE_EPROM);
            boot_source_strap_o    <= !(mode_ff == MODE_EPROM &&
                                        state_ff == BMSL_LOAD);
            eprom_rd_o   <= rd_pend_ff;
            eprom_addr_o <= raddr_ff - 10'h001;
            dma_wr_o     <= (state_ff == BMSL_LOAD ||
                             state_ff == BMSL_IDLE) && src_vld;
            dma_addr_o   <= cnt_ff[CNT_W-2:0];
            dma_data_o   <= src_word;
            core_run_o   <= (state_ff == BMSL_KERNEL ||
                             state_ff == BMSL_DONE);
            kernel_done_o      <= (state_ff != BMSL_SAMPLE &&
                                   state_ff != BMSL_IDLE &&
                                   state_ff != BMSL_LOAD);
            kernel_area_free_o <= (state_ff == BMSL_DONE);
            boot_mode_o  <= mode_ff;
        end
    end

    // Checks of the sequence.
    chk_strap_input : assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (state_ff == BMSL_SAMPLE) |=> !boot_source_strap_oe_o)
        else $error("strap driven while sampling");
    chk_eprom_select : assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (ce_i && mode_ff == MODE_EPROM) |=> boot_source_strap_oe_o)
        else $error("EPROM select not driven");
    chk_mode_hold : assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (state_ff == BMSL_LOAD && $past(state_ff == BMSL_LOAD))
            |-> $stable(mode_ff))
        else $error("boot mode changed during load");
    chk_kernel_count : assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (state_ff == BMSL_KERNEL && mode_ff != MODE_HOST)
            |-> cnt_ff == KERNEL_LAST)
        else $error("kernel length wrong");
    chk_dma_word : assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (ce_i && state_ff == BMSL_LOAD && src_vld)
            |=> dma_wr_o && dma_data_o == $past(src_word))
        else $error("DMA word not written");
    chk_run_after : assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (ce_i && state_ff == BMSL_KERNEL) |=> core_run_o)
        else $error("core not released");
    chk_idle_high : assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (state_ff == BMSL_IDLE) |-> !dma_wr_o && !core_run_o)
        else $error("activity while idle");
    chk_reuse_area : assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        kernel_area_free_o |-> core_run_o && kernel_done_o)
        else $error("kernel area freed early");
    cov_eprom : cover property (@(posedge clk_sys_i)
        mode_ff == MODE_EPROM && state_ff == BMSL_KERNEL);
    cov_host : cover property (@(posedge clk_sys_i)
        mode_ff == MODE_HOST && state_ff == BMSL_KERNEL);
    cov_link : cover property (@(posedge clk_sys_i)
        mode_ff == MODE_LINK && state_ff == BMSL_KERNEL);
endmodule : bmsl_loader
`default_nettype wire

// ---- bmsl_eprom_model.sv ----
// Byte-wide external boot memory that answers the loader's reads.
`timescale 1ns/1ps
`default_nettype none
module bmsl_eprom_model
    import bmsl_pkg::*;
(
    input  wire logic                          clk_sys_i,
    input  wire logic                          cs_n_i,
    input  wire logic [bmsl_pkg::EPROM_AW-1:0] addr_i,
    input  wire logic                          rd_i,
    output logic      [bmsl_pkg::EPROM_W-1:0]  data_o
);
    // Content of one byte location; each byte differs from its neighbours.
    function automatic logic [7:0] rom_byte(input logic [9:0] a);
        return a[7:0] ^ 8'hA5 ^ {6'h00, a[9:8]};
    endfunction

    // Bus level between reads; it toggles so a late sample never passes.
    logic [7:0] idle_ff = 8'h3C;
    always @(posedge clk_sys_i) begin
        idle_ff <= ~idle_ff;
    end

    // A selected read shows its byte while the read strobe stands, so the
    // loader finds it at the edge that ends the strobe.
    assign data_o = (rd_i && !cs_n_i) ? rom_byte(addr_i) : idle_ff;
endmodule // bmsl_eprom_model
`default_nettype wire

// ---- boot_mode_select_loader_tb_top.sv ----
// Self-checking testbench of the boot sequencer with an EPROM model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
    bad_count++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
    end end
module boot_mode_select_loader_tb_top;
    import bmsl_pkg::*;
    // One row: strap level, link source, word count, expected mode.
    typedef struct packed {
        logic       s;
        logic       l;
        logic [8:0] n;
        logic [1:0] m;
    } bmsl_row_t;
    bmsl_row_t   rows [4];       // Ordinary boot cases.
    logic        clk_sys_i = 0;  // System clock.
    logic        arst_n_i = 0;   // Reset, active low.
    logic        strap_lvl = 0;  // Board level on the strap pin.
    logic        host_wr = 0;    // Host word strobe.
    logic        host_last = 0;  // Host last-word flag.
    logic        link_vld = 0;   // Link word strobe.
    logic        init_done = 0;  // Kernel finished system set-up.
    logic        ce = 1;         // Clock enable of the loader.
    logic [31:0] in_data = 0;    // Word offered by host or link.
    logic        strap_o, strap_oe, strap_pin, eprom_rd, dma_wr;
    logic        core_run, kdone, kfree;
    logic [9:0]  eprom_addr;
    logic [7:0]  eprom_data, dma_addr;
    logic [31:0] dma_data;
    logic [1:0]  mode;
    logic [31:0] mem [256];      // Words seen on the DMA channel.
    int          dma_cnt = 0;    // DMA writes since the last reset.
    int          bad_count = 0;  // Mismatches.
    int          checks_done = 0; // Comparisons made.
    int          i;              // Wait counter.

    // The pin level: the loader when it drives, the board otherwise.
    assign strap_pin = strap_oe ? strap_o : strap_lvl;

    // Half-period toggle gives the 200 MHz clock.
    always #2.5 clk_sys_i = ~clk_sys_i;

    bmsl_loader DUT (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce),
        .boot_source_strap_i(strap_pin), .boot_source_strap_o(strap_o),
        .boot_source_strap_oe_o(strap_oe), .eprom_addr_o(eprom_addr),
        .eprom_rd_o(eprom_rd), .eprom_data_i(eprom_data),
        .host_boot_dma_port_wr_i(host_wr),
        .host_boot_dma_port_data_i(in_data), .host_last_i(host_last),
        .link_vld_i(link_vld), .link_data_i(in_data), .dma_wr_o(dma_wr),
        .dma_addr_o(dma_addr), .dma_data_o(dma_data),
        .core_run_o(core_run), .kernel_done_o(kdone),
        .kernel_area_free_o(kfree), .kernel_init_done_i(init_done),
        .boot_mode_o(mode));

    bmsl_eprom_model u_rom (.clk_sys_i(clk_sys_i), .cs_n_i(strap_pin),
        .addr_i(eprom_addr), .rd_i(eprom_rd), .data_o(eprom_data));

    // Record every word the DMA channel writes.
    always @(posedge clk_sys_i) begin
        if (dma_wr === 1'b1 && ce) begin
            mem[dma_addr] = dma_data;
            dma_cnt++;
        end
    end

    // Word pattern offered by host or link; three byte lanes vary with the word, one holds 3C.
    function automatic logic [31:0] wval(input int w);
        return {w[7:0], ~w[7:0], 8'h3C, w[7:0] ^ 8'h81};
    endfunction

    // Hold reset ten cycles with the strap set, the pin an input.
    task automatic do_reset(input logic s);
        @(negedge clk_sys_i);
        arst_n_i = 0;
        strap_lvl = s;
        init_done = 0;
        repeat (10) @(negedge clk_sys_i);
        `CHK("strap_oe_in_reset", 1'b0, strap_oe)
        dma_cnt = 0;
        arst_n_i = 1;
    endtask

    // Back-to-back words, one per cycle, flag on the last if asked.
    task automatic send(input logic lnk, input int n, input logic last);
        for (int w = 0; w < n; w++) begin
            in_data = wval(w);
            host_last = last && (w == n - 1);
            host_wr = !lnk;
            link_vld = lnk;
            @(negedge clk_sys_i);
        end
        host_wr = 0;
        link_vld = 0;
        host_last = 0;
    endtask

    // One complete boot from reset to freeing the kernel area.
    task automatic run_case(input bmsl_row_t r);
        logic [31:0] ex;
        do_reset(r.s);
        if (!r.s) begin
            for (i = 0; i < 200 && dma_cnt == 0; i++) @(negedge clk_sys_i);
            `CHK("eprom_select", 1'b0, strap_o)
            `CHK("strap_drive", 1'b1, strap_oe)
        end else begin
            repeat (20) @(negedge clk_sys_i);
            strap_lvl = 0; // Late pin change must not alter the mode.
            send(r.l, int'(r.n), r.n < 9'h100);
        end
        for (i = 0; i < 6000 && kdone !== 1'b1; i++) @(negedge clk_sys_i);
        repeat (4) @(negedge clk_sys_i);
        `CHK("kernel_done", 1'b1, kdone)
        `CHK("word_count", int'(r.n), dma_cnt)
        `CHK("boot_mode", r.m, mode)
        `CHK("strap_oe", !r.s, strap_oe)
        `CHK("core_run", 1'b1, core_run)
        for (int w = 0; w < int'(r.n); w++) begin
            ex = r.s ? wval(w) : {u_rom.rom_byte(10'(4 * w + 3)),
                u_rom.rom_byte(10'(4 * w + 2)),
                u_rom.rom_byte(10'(4 * w + 1)), u_rom.rom_byte(10'(4 * w))};
            `CHK("dma_word", ex, mem[w])
        end
        `CHK("area_busy", 1'b0, kfree)
        init_done = 1;
        for (i = 0; i < 20 && kfree !== 1'b1; i++) @(negedge clk_sys_i);
        `CHK("area_free", 1'b1, kfree)
    endtask

    // Print the counts and the verdict, then stop.
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the expected run length.
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        bad_count++;
        $display("Watchdog expired");
        finish_test;
    end

    // Table cases first, then reset and refusal cases by hand.
    initial begin
        rows[0] = '{1'b0, 1'b0, 9'h100, MODE_EPROM};
        rows[1] = '{1'b1, 1'b0, 9'h100, MODE_HOST};
        rows[2] = '{1'b1, 1'b1, 9'h100, MODE_LINK};
        rows[3] = '{1'b1, 1'b0, 9'h005, MODE_HOST};
        foreach (rows[k]) run_case(rows[k]);
        send(1'b0, 1, 1'b0); // A word after the load must be dropped.
        repeat (10) @(negedge clk_sys_i);
        `CHK("late_word", 5, dma_cnt)
        do_reset(1'b0);
        for (i = 0; i < 200 && dma_cnt < 3; i++) @(negedge clk_sys_i);
        ce = 0; // A low clock enable must freeze the EPROM fetch.
        i = eprom_addr;
        repeat (20) @(negedge clk_sys_i);
        `CHK("ce_freeze", i, eprom_addr)
        ce = 1;
        arst_n_i = 0;
        #1;
        `CHK("rst_select", 1'b1, strap_o)
        `CHK("rst_mode", 2'h0, mode)
        `CHK("rst_done", 1'b0, kdone)
        do_reset(1'b1);
        send(1'b0, 2, 1'b0); // Words before the strap is sampled.
        repeat (20) @(negedge clk_sys_i);
        `CHK("early_words", 0, dma_cnt)
        finish_test;
    end
endmodule // boot_mode_select_loader_tb_top
`default_nettype wire
